// [rtl/fbc_pkg.sv]
// Purpose: Shared constants and types for the flash bus controller
// Assumes: 125 MHz clock, 16-bit parallel flash with command interface
// Notes:   Identifier offsets are word offsets added to a block base
package fbc_pkg;

  localparam int unsigned CLK_PERIOD_PS = 8000;

  // Bus timing in ns
  localparam int unsigned RESET_PULSE_MIN_NS       = 100;
  localparam int unsigned RESET_TO_READ_DELAY_NS   = 150;
  localparam int unsigned WRITE_AFTER_RESET_NS     = 150;
  localparam int unsigned ABORT_SHUTDOWN_TIME_NS   = 20000;
  localparam int unsigned READ_ACCESS_NS           = 70;
  localparam int unsigned WRITE_PULSE_NS           = 45;
  localparam int unsigned WRITE_RECOVERY_NS        = 30;

  // Least times round up to whole cycles
  function automatic int unsigned cyc_up(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned RESET_PULSE_CYC  = cyc_up(RESET_PULSE_MIN_NS);
  localparam int unsigned READ_WAIT_CYC    = cyc_up(RESET_TO_READ_DELAY_NS);
  localparam int unsigned WRITE_WAIT_CYC   = cyc_up(WRITE_AFTER_RESET_NS);
  localparam int unsigned ABORT_CYC        = cyc_up(ABORT_SHUTDOWN_TIME_NS);
  localparam int unsigned ACCESS_CYC       = cyc_up(READ_ACCESS_NS);
  localparam int unsigned WPULSE_CYC       = cyc_up(WRITE_PULSE_NS);
  localparam int unsigned WRECOV_CYC       = cyc_up(WRITE_RECOVERY_NS);

  // Commands
  localparam logic [15:0] CMD_READ_ARRAY = 16'h00FF;
  localparam logic [15:0] CMD_READ_IDENT = 16'h0090;

  // Identifier offsets
  localparam logic [7:0] OFS_MAKER_CODE = 8'h00;
  localparam logic [7:0] OFS_PART_CODE  = 8'h01;
  localparam logic [7:0] OFS_BLOCK_LOCK = 8'h02;
  localparam logic [7:0] OFS_PROT_LOCK  = 8'h80;
  localparam logic [7:0] OFS_OTP_FIRST  = 8'h81;
  localparam int unsigned OTP_WORDS     = 8;

  // Block lock bits in the lock-state word
  localparam int unsigned LOCK_BIT      = 0;
  localparam int unsigned LOCKDOWN_BIT  = 1;

  // Controller operations
  typedef enum logic [2:0] {
    FBC_OP_READ    = 3'h0,
    FBC_OP_WRITE   = 3'h1,
    FBC_OP_ARRAY   = 3'h2,
    FBC_OP_IDENT   = 3'h3,
    FBC_OP_IDREAD  = 3'h4,
    FBC_OP_RESET   = 3'h5,
    FBC_OP_ABORT   = 3'h6
  } fbc_op_t;

  typedef struct packed {
    fbc_op_t     op;
    logic [21:0] addr;
    logic [15:0] data;
  } fbc_req_t;

  // Pins toward the flash, all levels
  typedef struct packed {
    logic        sel_n;
    logic        oe_n;
    logic        we_n;
    logic        rst_pd_n;
    logic [21:0] addr;
    logic [15:0] dq_out;
    logic        dq_oe_n;
  } fbc_pins_t;

endpackage

// [rtl/fbc_sync.sv]
// Purpose: Three-stage synchroniser for the flash data lines
// Assumes: Data pins are asynchronous to clock_i
// Notes:   A value is accepted once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module fbc_sync #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input  wire logic         clock_i,
  input  wire logic         arst_n_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_nxt;

  // Only stage two reads stage one
  always_comb begin
    q_nxt = (s2_r == s3_r) ? s3_r : q_o;
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_o  <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_o  <= q_nxt;
    end
  end

endmodule
`default_nettype wire

// [rtl/fbc_host.sv]
// Purpose: Host controller driving a parallel boot-block flash bus
// Assumes: One request at a time; flash timing met by cycle counts
// Notes:   Program and erase sequencing is left to the user side
`timescale 1ns/100ps
`default_nettype none
module fbc_host #(
  parameter int unsigned ABORT_CYCLES = fbc_pkg::ABORT_CYC
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             arst_n_i,
  // User request
  input  wire logic             req_valid_i,
  input  wire fbc_pkg::fbc_req_t req_i,
  output var  logic             req_ready_o,
  output var  logic             rsp_valid_o,
  output var  logic [15:0]      rsp_data_o,
  output var  logic             ident_mode_o,
  // Flash pins
  output var  fbc_pkg::fbc_pins_t pins_o,
  input  wire logic [15:0]      dq_i
);

  typedef enum logic [6:0] {
    ST_IDLE   = 7'b000_0001,
    ST_RD     = 7'b000_0010,
    ST_WR     = 7'b000_0100,
    ST_WREC   = 7'b000_1000,
    ST_RSTLO  = 7'b001_0000,
    ST_ABORT  = 7'b010_0000,
    ST_WAKE   = 7'b100_0000
  } fbc_st_t;

  localparam int unsigned CW = $clog2(ABORT_CYCLES + fbc_pkg::WRITE_WAIT_CYC + 2);

  fbc_st_t            st_r, st_nxt;
  logic [CW-1:0]      cnt_r, cnt_nxt;
  logic [CW-1:0]      wake_r, wake_nxt;
  logic               ident_r, ident_nxt;
  logic               post_r, post_nxt;
  logic               rsp_v_nxt;
  logic [15:0]        rsp_d_nxt;
  fbc_pkg::fbc_pins_t pins_nxt;
  fbc_pkg::fbc_req_t  cur_r, cur_nxt;
  logic [15:0]        dq_sync;

  fbc_sync #(
    .W (16)
  ) u_sync (
    .clock_i  (clock_i),
    .arst_n_i (arst_n_i),
    .d_i      (dq_i),
    .q_o      (dq_sync)
  );

  function automatic logic [CW-1:0] cw(input int unsigned v);
    return CW'(v);
  endfunction

  // Identifier address: block base with offset in low byte
  function automatic logic [21:0] id_addr(input logic [21:0] base, input logic [7:0] ofs);
    return {base[21:8], ofs};
  endfunction

  // Idle bus: deselected, data floating
  function automatic fbc_pkg::fbc_pins_t idle_pins(input logic rp);
    fbc_pkg::fbc_pins_t p;
    p          = '0;
    p.sel_n    = 1'b1;
    p.oe_n     = 1'b1;
    p.we_n     = 1'b1;
    p.rst_pd_n = rp;
    p.dq_oe_n  = 1'b1;
    return p;
  endfunction

  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    wake_nxt  = wake_r;
    ident_nxt = ident_r;
    post_nxt  = post_r;
    cur_nxt   = cur_r;
    rsp_v_nxt = 1'b0;
    rsp_d_nxt = rsp_data_o;
    pins_nxt  = pins_o;
    if (wake_r != '0) begin
      wake_nxt = wake_r - cw(1);
    end
    unique case (st_r)
      ST_IDLE: begin
        pins_nxt = idle_pins(1'b1);
        if (req_valid_i) begin
          cur_nxt = req_i;
          unique case (req_i.op)
            fbc_pkg::FBC_OP_READ, fbc_pkg::FBC_OP_IDREAD: begin
              if (wake_r == '0) begin
                st_nxt        = ST_RD;
                cnt_nxt       = cw(fbc_pkg::ACCESS_CYC);
                pins_nxt.addr = req_i.addr;
                if (req_i.op == fbc_pkg::FBC_OP_IDREAD) begin
                  pins_nxt.addr = id_addr(req_i.addr, req_i.data[7:0]);
                end
                pins_nxt.sel_n = 1'b0;
                pins_nxt.oe_n  = 1'b0;
              end
            end
            fbc_pkg::FBC_OP_RESET, fbc_pkg::FBC_OP_ABORT: begin
              st_nxt            = ST_RSTLO;
              cnt_nxt           = cw(fbc_pkg::RESET_PULSE_CYC);
              post_nxt          = (req_i.op == fbc_pkg::FBC_OP_ABORT);
              pins_nxt.rst_pd_n = 1'b0;
            end
            default: begin
              // Writes wait out the post-reset write delay
              if (wake_r == '0) begin
                st_nxt           = ST_WR;
                cnt_nxt          = cw(fbc_pkg::WPULSE_CYC);
                pins_nxt.addr    = req_i.addr;
                pins_nxt.dq_out  = req_i.data;
                if (req_i.op == fbc_pkg::FBC_OP_ARRAY) begin
                  pins_nxt.dq_out = fbc_pkg::CMD_READ_ARRAY;
                end else if (req_i.op == fbc_pkg::FBC_OP_IDENT) begin
                  pins_nxt.dq_out = fbc_pkg::CMD_READ_IDENT;
                end
                pins_nxt.dq_oe_n = 1'b0;
                pins_nxt.sel_n   = 1'b0;
                pins_nxt.we_n    = 1'b0;
              end
            end
          endcase
        end
      end
      ST_RD: begin
        cnt_nxt = cnt_r - cw(1);
        // Sampled after access time plus synchroniser depth
        if (cnt_r == cw(1)) begin
          st_nxt    = ST_WREC;
          cnt_nxt   = cw(3);
          pins_nxt  = idle_pins(1'b1);
        end
      end
      ST_WR: begin
        cnt_nxt = cnt_r - cw(1);
        if (cnt_r == cw(1)) begin
          // Strobe rises first; select follows in recovery
          pins_nxt.we_n = 1'b1;
          st_nxt        = ST_WREC;
          cnt_nxt       = cw(fbc_pkg::WRECOV_CYC);
          unique case (cur_r.op)
            fbc_pkg::FBC_OP_ARRAY: ident_nxt = 1'b0;
            fbc_pkg::FBC_OP_IDENT: ident_nxt = 1'b1;
            default: begin
              if (cur_r.data[7:0] == fbc_pkg::CMD_READ_ARRAY[7:0]) begin
                ident_nxt = 1'b0;
              end else if (cur_r.data[7:0] == fbc_pkg::CMD_READ_IDENT[7:0]) begin
                ident_nxt = 1'b1;
              end
            end
          endcase
        end
      end
      ST_WREC: begin
        pins_nxt = idle_pins(1'b1);
        cnt_nxt  = cnt_r - cw(1);
        if (cnt_r == cw(1)) begin
          st_nxt = ST_IDLE;
          if (cur_r.op == fbc_pkg::FBC_OP_READ || cur_r.op == fbc_pkg::FBC_OP_IDREAD) begin
            rsp_v_nxt = 1'b1;
            rsp_d_nxt = dq_sync;
          end else begin
            rsp_v_nxt = 1'b1;
            rsp_d_nxt = 16'h0000;
          end
        end
      end
      ST_RSTLO: begin
        cnt_nxt = cnt_r - cw(1);
        if (cnt_r == cw(1)) begin
          if (post_r) begin
            st_nxt  = ST_ABORT;
            cnt_nxt = cw(ABORT_CYCLES);
          end else begin
            st_nxt  = ST_WAKE;
          end
        end
      end
      ST_ABORT: begin
        // Reset stays low through shutdown, so delays count from its end
        cnt_nxt = cnt_r - cw(1);
        if (cnt_r == cw(1)) begin
          st_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        pins_nxt  = idle_pins(1'b1);
        ident_nxt = 1'b0;
        wake_nxt  = cw(fbc_pkg::WRITE_WAIT_CYC > fbc_pkg::READ_WAIT_CYC ?
                       fbc_pkg::WRITE_WAIT_CYC : fbc_pkg::READ_WAIT_CYC);
        st_nxt    = ST_IDLE;
        rsp_v_nxt = 1'b1;
        rsp_d_nxt = 16'h0000;
      end
      default: begin
        st_nxt   = ST_IDLE;
        pins_nxt = idle_pins(1'b1);
      end
    endcase
  end

  // Flash reset tracks the controller reset
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r         <= ST_WAKE;
      cnt_r        <= '0;
      wake_r       <= '0;
      ident_r      <= 1'b0;
      post_r       <= 1'b0;
      cur_r        <= '0;
      rsp_valid_o  <= 1'b0;
      rsp_data_o   <= 16'h0000;
      pins_o       <= {1'b1, 1'b1, 1'b1, 1'b0, 22'h00_0000, 16'h0000, 1'b1};
    end else begin
      st_r         <= st_nxt;
      cnt_r        <= cnt_nxt;
      wake_r       <= wake_nxt;
      ident_r      <= ident_nxt;
      post_r       <= post_nxt;
      cur_r        <= cur_nxt;
      rsp_valid_o  <= rsp_v_nxt;
      rsp_data_o   <= rsp_d_nxt;
      pins_o       <= pins_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_ready_o  <= 1'b0;
      ident_mode_o <= 1'b0;
    end else begin
      req_ready_o  <= (st_nxt == ST_IDLE) && !(st_r == ST_IDLE && req_valid_i);
      ident_mode_o <= ident_nxt;
    end
  end

endmodule
`default_nettype wire

// [test/fbc_flash_model.sv]
// Purpose: Behavioural flash device facing the host controller
// Assumes: Pins arrive as one struct; data lines have no pull
// Notes:   Default codes are arbitrary, not those of any real part
`timescale 1ns/100ps
`default_nettype none
module fbc_flash_model #(
  parameter logic [15:0] MAKER  = 16'h5A5A,
  parameter logic [15:0] PART   = 16'h3C3C,
  parameter logic [15:0] PLOCK  = 16'h0002,
  parameter int          ACC_NS = 20
) (
  // Flash pins
  input  wire fbc_pkg::fbc_pins_t pins_i,
  output wire logic [15:0]        dq_o
);
  logic        ident_r = 1'b0;
  logic [15:0] last_r  = 16'h0000;
  logic [15:0] word;
  wire rd_on = !pins_i.sel_n && !pins_i.oe_n && pins_i.we_n && pins_i.rst_pd_n;
  wire wr_on = !pins_i.sel_n && !pins_i.we_n && pins_i.oe_n && pins_i.rst_pd_n;
  // First rising strobe or select ends wr_on, so that is the latch point
  // Mode survives deselect; only a latch or a reset moves it
  always @(negedge wr_on or negedge pins_i.rst_pd_n) begin
    if (!pins_i.rst_pd_n) ident_r <= 1'b0;
    else if (pins_i.dq_out == 16'h0090) ident_r <= 1'b1;
    else if (pins_i.dq_out == 16'h00FF) ident_r <= 1'b0;
  end
  always_comb begin
    word = pins_i.addr[15:0] ^ 16'hA5A5;
    if (ident_r) begin
      case (pins_i.addr[7:0])
        8'h00:   word = MAKER;
        8'h01:   word = PART;
        8'h02:   word = 16'h0001;
        8'h80:   word = PLOCK;
        default: word = (pins_i.addr[7:0] inside {[8'h81:8'h88]}) ? {8'h0F, pins_i.addr[7:0]} : '0;
      endcase
    end
  end
  always @(word or rd_on) if (rd_on) last_r = word;
  // Released lines show the inverse of the last word, so a stale sample fails
  assign #(ACC_NS) dq_o = rd_on ? word : ~last_r;
endmodule
`default_nettype wire

// [test/fbc_host_chk.sv]
// Purpose: Port checker for the flash host controller
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Wait counters saturate, so long holds never wrap
`timescale 1ns/100ps
`default_nettype none
module fbc_host_chk #(
  parameter int unsigned ABORT_CYCLES = fbc_pkg::ABORT_CYC
) (
  // Clock and reset
  input wire logic               clock_i,
  input wire logic               arst_n_i,
  // User side
  input wire logic               req_valid_i,
  input wire fbc_pkg::fbc_req_t  req_i,
  input wire logic               req_ready_o,
  input wire logic               rsp_valid_o,
  input wire logic [15:0]        rsp_data_o,
  input wire logic               ident_mode_o,
  // Flash side
  input wire fbc_pkg::fbc_pins_t pins_o,
  input wire logic [15:0]        dq_i
);
  logic [7:0] lo_r, lo_nxt, hi_r, hi_nxt;
  always_comb begin
    lo_nxt = pins_o.rst_pd_n ? 8'h00 : lo_r + {7'h00, lo_r != 8'hFF};
    hi_nxt = !pins_o.rst_pd_n ? 8'h00 : hi_r + {7'h00, hi_r != 8'hFF};
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lo_r <= 8'hFF;
      hi_r <= 8'h00;
    end else begin
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
    end
  end
  default clocking dc @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  read_strobes_a: assert property (
    !pins_o.oe_n |-> !pins_o.sel_n && pins_o.we_n && pins_o.rst_pd_n && pins_o.dq_oe_n)
    else $error("read strobes in a wrong combination");
  write_strobes_a: assert property (
    !pins_o.we_n |-> !pins_o.sel_n && pins_o.oe_n && pins_o.rst_pd_n && !pins_o.dq_oe_n)
    else $error("write strobes in a wrong combination");
  write_hold_a: assert property (
    $rose(pins_o.we_n) |-> !pins_o.sel_n && $stable(pins_o.addr) && $stable(pins_o.dq_out))
    else $error("address or data moved at the latch edge");
  standby_idle_a: assert property (
    pins_o.sel_n |-> pins_o.oe_n && pins_o.we_n && pins_o.dq_oe_n)
    else $error("strobe or data drive while deselected");
  reset_pulse_a: assert property (
    $rose(pins_o.rst_pd_n) |-> lo_r >= fbc_pkg::RESET_PULSE_CYC)
    else $error("flash reset pulse too short");
  wake_wait_a: assert property (
    $fell(pins_o.sel_n) |-> hi_r >= fbc_pkg::WRITE_WAIT_CYC)
    else $error("access too soon after flash reset");
  ident_enter_a: assert property (
    $rose(ident_mode_o) |-> $rose(pins_o.we_n) && $past(pins_o.dq_out) == fbc_pkg::CMD_READ_IDENT)
    else $error("identifier mode without its command");
  ident_exit_a: assert property (
    $fell(ident_mode_o) |-> ($rose(pins_o.we_n) && $past(pins_o.dq_out) == fbc_pkg::CMD_READ_ARRAY)
      || !pins_o.rst_pd_n || !$past(pins_o.rst_pd_n))
    else $error("identifier mode left without command or reset");
  cover property (ident_mode_o && rsp_valid_o);
  cover property ($rose(pins_o.rst_pd_n) && lo_r >= ABORT_CYCLES);
  cover property ($rose(pins_o.oe_n) && pins_o.rst_pd_n);
endmodule
bind fbc_host fbc_host_chk #(.ABORT_CYCLES(ABORT_CYCLES)) u_chk (.clock_i, .arst_n_i,
  .req_valid_i, .req_i, .req_ready_o, .rsp_valid_o, .rsp_data_o, .ident_mode_o, .pins_o, .dq_i);
`default_nettype wire

// [test/fbc_host_tb_top.sv]
// Purpose: Self-checking bench for the flash host controller
// Assumes: Behavioural flash model on the far side of the pins
// Notes:   Shutdown wait shortened so the abort case stays quick
`timescale 1ns/100ps
`default_nettype none
module fbc_host_tb_top;
  localparam logic [15:0] MAKER = 16'h5A5A; // Arbitrary code
  localparam logic [15:0] PART  = 16'h3C3C; // Arbitrary code
  localparam logic [15:0] PLOCK = 16'h0002;
  logic               clock_i     = 1'b0;
  logic               arst_n_i    = 1'b0;
  logic               req_valid_i = 1'b0;
  fbc_pkg::fbc_req_t  req_i       = '0;
  logic               req_ready_o, rsp_valid_o, ident_mode_o;
  logic [15:0]        rsp_data_o;
  fbc_pkg::fbc_pins_t pins_o;
  wire [15:0]         dq_i;
  logic [15:0]        exp_q[$];
  logic [7:0]         tbl[4] = '{8'h00, 8'h01, 8'h02, 8'h80};
  logic [7:0]         ofs;
  logic [21:0]        ra;
  int                 n_errors = 0;
  int                 compares = 0;
  always #4 clock_i = ~clock_i;
  fbc_host #(.ABORT_CYCLES(10)) dut (.clock_i, .arst_n_i, .req_valid_i, .req_i,
    .req_ready_o, .rsp_valid_o, .rsp_data_o, .ident_mode_o, .pins_o, .dq_i);
  fbc_flash_model #(.MAKER(MAKER), .PART(PART), .PLOCK(PLOCK), .ACC_NS(20)) u_flash (
    .pins_i(pins_o), .dq_o(dq_i));
  task automatic tally_and_finish();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic mism(input string m);
    n_errors++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  function automatic logic [15:0] id_exp(input logic [7:0] o);
    case (o)
      8'h00:   return MAKER;
      8'h01:   return PART;
      8'h02:   return 16'h0001;
      8'h80:   return PLOCK;
      default: return {8'h0F, o};
    endcase
  endfunction
  // Valid drops once the pins show the take; held to the answer, an idle edge would retake it
  task automatic do_op(input logic [2:0] op, input logic [21:0] a, input logic [15:0] d,
                       input logic [15:0] e);
    int n;
    n = 0;
    exp_q.push_back(e);
    req_i = '{op: fbc_pkg::fbc_op_t'(op), addr: a, data: d};
    req_valid_i = 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pins_o.sel_n !== 1'b0 && pins_o.rst_pd_n !== 1'b0 && n < 5000);
    #1 req_valid_i = 1'b0;
    compares++;
    if (req_ready_o !== 1'b0) mism("ready while busy");
    do begin
      @(posedge clock_i);
      n++;
    end while (rsp_valid_o !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      mism("no response");
      tally_and_finish();
    end
    compares++;
    if (req_ready_o !== 1'b1) mism("not ready after response");
    @(posedge clock_i);
    #1;
  endtask
  task automatic chk_ident(input logic e);
    compares++;
    if (ident_mode_o !== e) mism("identifier mode flag");
  endtask
  always @(posedge clock_i) begin
    if (rsp_valid_o === 1'b1) begin
      compares++;
      if (exp_q.size() == 0) mism("unexpected response");
      else if (rsp_data_o !== exp_q.pop_front()) mism("response data");
    end
  end
  initial begin
    void'($urandom(67));
    exp_q.push_back(16'h0000);
    repeat (5) @(posedge clock_i);
    compares++;
    if (pins_o.rst_pd_n !== 1'b0) mism("flash reset free during reset");
    #1 arst_n_i = 1'b1;
    repeat (4) @(posedge clock_i);
    #1 ra = 22'($urandom);
    do_op(3'h0, ra, 16'h0000, ra[15:0] ^ 16'hA5A5);
    do_op(3'h3, 22'($urandom), 16'h0000, 16'h0000);
    chk_ident(1'b1);
    for (int i = 0; i < 12; i++) begin
      ofs = (i < 4) ? tbl[i] : 8'(8'h7D + i);
      do_op(3'h4, {14'($urandom), 8'h00}, {8'h00, ofs}, id_exp(ofs));
    end
    do_op(3'h2, 22'($urandom), 16'h0000, 16'h0000);
    chk_ident(1'b0);
    ra = 22'($urandom);
    do_op(3'h0, ra, 16'h0000, ra[15:0] ^ 16'hA5A5);
    do_op(3'h1, 22'($urandom), 16'h0090, 16'h0000);
    do_op(3'h4, {14'($urandom), 8'h00}, 16'h0001, PART);
    do_op(3'h5, 22'h00_0000, 16'h0000, 16'h0000);
    chk_ident(1'b0);
    ra = 22'($urandom);
    do_op(3'h0, ra, 16'h0000, ra[15:0] ^ 16'hA5A5);
    do_op(3'h3, 22'($urandom), 16'h0000, 16'h0000);
    do_op(3'h6, 22'h00_0000, 16'h0000, 16'h0000);
    chk_ident(1'b0);
    for (int i = 0; i < 4; i++) begin
      ra = 22'($urandom);
      do_op(3'h0, ra, 16'h0000, ra[15:0] ^ 16'hA5A5);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
